// [src/instr_decode_14bit.sv]
/*
 Instruction decoder and sequencer for a 14-bit-word 8-bit controller core.
 Assumes program memory answers pc_o combinationally on instr_i, file memory
 returns read data the cycle after file_rd_o, and inputs are synchronous.
*/
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// - Instruction words are 14 bits: opcode field plus operand fields.
// - Byte ops write result to accumulator when d is 0, file when 1.
// - File operand is a 7-bit direct address, 0x00 to 0x7F.
// - One instruction cycle is four clock periods.
// - Skips and program counter changes take two cycles, second a no-op.
// - File instructions read, modify, write; port read clears port-change condition.
// - Reads of the port register take pin levels, not the output latch.
// - Writing the timer count clears prescaler when assigned to the timer.
// - Byte ops: top 00, 4-bit code; add 0111, and 0101, or 0100.
// - Decrement/increment skip-if-zero update target, skip on zero, no flags.
// - Rotates go through carry and change only carry.
// - Bit ops: top 01, codes clear, set, skip-if-clear, skip-if-set.
// - Bit index selects one of eight bits of the file register.
// - Literal or 1000, and 1001, add 111x; and/or update only zero.
// - Subtract-from-immediate 110x updates carry, digit carry and zero.
// - Immediate xor updates zero; immediate load touches no flags.
// - Return-with-immediate loads accumulator, returns, takes two cycles.
// - Call and jump carry 11-bit targets and take two cycles.
// - Standby and watchdog-kick words update timeout and sleep flags.
// - Don't-care encoding bits are ignored.
// - Kick and standby clear watchdog and its prescaler when assigned.
// - Standby clears sleep-entered flag, sets timeout flag, watchdog runs.
// - A met skip discards the fetched next instruction as a no-op.
module instr_decode_14bit #(
   parameter int PC_W = instr_decode_pkg::PC_W,
   parameter int STACK_D = instr_decode_pkg::STACK_D
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Program memory
   output logic [PC_W-1:0] pc_o,
   input wire logic [instr_decode_pkg::INSTR_W-1:0] instr_i,
   // File register space
   output logic [instr_decode_pkg::FADDR_W-1:0] file_addr_o,
   output logic file_rd_o,
   input wire logic [instr_decode_pkg::DATA_W-1:0] file_rdata_i,
   output logic file_wr_o,
   output logic [instr_decode_pkg::DATA_W-1:0] file_wdata_o,
   input wire logic [instr_decode_pkg::DATA_W-1:0] pin_level_i,
   // Side effects and core state
   output logic prescaler_clear_o,
   output logic wdt_clear_o,
   output logic port_change_clear_o,
   output logic standby_o,
   input wire logic wake_i,
   output logic [instr_decode_pkg::DATA_W-1:0] acc_o,
   output logic carry_o,
   output logic digit_carry_o,
   output logic zero_o,
   output logic timeout_flag_o,
   output logic sleep_entered_flag_o,
   // Register port
   input wire logic [instr_decode_pkg::REG_ADDR_W-1:0] reg_addr_i,
   input wire logic [instr_decode_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [instr_decode_pkg::REG_DATA_W-1:0] reg_rdata_o
);

   localparam int SP_W = $clog2(STACK_D);

   instr_decode_pkg::phase_type ph_reg;
   instr_decode_pkg::phase_type ph_next;
   logic [13:0] ir_reg;
   logic discard_reg;
   logic hold_reg;
   logic [1:0] ctrl_reg;
   logic [SP_W-1:0] sp_reg;
   logic [PC_W-1:0] stack_mem [STACK_D];

   ////////////////////////////////////////////////////////////////////////
   // Field decode

   wire [1:0] grp = ir_reg[13:12];
   wire [3:0] opc = ir_reg[11:8];
   wire d_bit = ir_reg[7];
   wire [6:0] faddr = ir_reg[6:0];
   wire [2:0] bsel = ir_reg[9:7];
   wire [1:0] bcode = ir_reg[11:10];
   wire [7:0] lit = ir_reg[7:0];
   wire [PC_W-1:0] target = ir_reg[PC_W-1:0];

   wire is_byte = (grp == instr_decode_pkg::GRP_BYTE);
   wire is_bit = (grp == instr_decode_pkg::GRP_BIT);
   wire is_lit = (grp == instr_decode_pkg::GRP_LIT);
   wire no_file = (opc == instr_decode_pkg::OP_MISC) | (opc == instr_decode_pkg::OP_CLR);
   // Every file-naming instruction reads first, even pure writes
   wire file_op = is_bit | (is_byte & ~(no_file & ~d_bit));
   wire run = ctrl_reg[instr_decode_pkg::CTRL_RUN_BIT];
   wire psa_tmr = ctrl_reg[instr_decode_pkg::CTRL_PSA_TMR_BIT];
   wire go = run & ~standby_o;
   wire at_exec = (ph_reg == instr_decode_pkg::PH_EXEC);
   wire at_decode = (ph_reg == instr_decode_pkg::PH_DECODE);
   wire at_fetch = (ph_reg == instr_decode_pkg::PH_FETCH);

   ////////////////////////////////////////////////////////////////////////
   // Operand and adder

   // Port reads return what the pins carry
   wire port_hit = (file_addr_o == instr_decode_pkg::PORT_ADDR);
   wire [7:0] fval = port_hit ? pin_level_i : file_rdata_i;
   wire [7:0] b = is_lit ? lit : fval;
   wire sub_sel = (is_byte & (opc == instr_decode_pkg::OP_SUB)) | (is_lit & (opc[3:1] == 3'h6));
   wire [7:0] y = sub_sel ? ~acc_o : acc_o;
   // Carry out of bit 7, digit carry out of bit 3
   wire [8:0] sum9 = {1'b0, b} + {1'b0, y} + {8'h00, sub_sel};
   wire [4:0] nib5 = {1'b0, b[3:0]} + {1'b0, y[3:0]} + {4'h0, sub_sel};
   wire [7:0] b_inc = b + 8'h01;
   wire [7:0] b_dec = b - 8'h01;
   wire [7:0] bmask = 8'h01 << bsel;

   ////////////////////////////////////////////////////////////////////////
   // Execute decode

   logic [7:0] res;
   logic c_val;
   logic wc;
   logic wdc;
   logic wz;
   logic to_acc;
   logic to_file;
   logic skip;
   logic jump;
   logic push;
   logic pop;
   logic sleep_hit;
   logic kick_hit;

   always_comb begin
      res = sum9[7:0];
      c_val = sum9[8];
      wc = 1'b0;
      wdc = 1'b0;
      wz = 1'b0;
      to_acc = 1'b0;
      to_file = 1'b0;
      skip = 1'b0;
      jump = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      sleep_hit = 1'b0;
      kick_hit = 1'b0;
      case (grp)
         instr_decode_pkg::GRP_BYTE: begin
            to_acc = ~d_bit;
            to_file = d_bit;
            case (opc)
               instr_decode_pkg::OP_MISC: begin
                  res = acc_o;
                  to_acc = 1'b0;
                  case (ir_reg)
                     instr_decode_pkg::W_RETURN: pop = 1'b1;
                     instr_decode_pkg::W_RETINT: pop = 1'b1;
                     instr_decode_pkg::W_SLEEP: sleep_hit = 1'b1;
                     instr_decode_pkg::W_KICK: kick_hit = 1'b1;
                     default: ;
                  endcase
               end
               instr_decode_pkg::OP_CLR: begin
                  res = 8'h00;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_SUB: begin
                  wc = 1'b1;
                  wdc = 1'b1;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_DEC: begin
                  res = b_dec;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_IOR: begin
                  res = b | acc_o;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_AND: begin
                  res = b & acc_o;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_XOR: begin
                  res = b ^ acc_o;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_ADD: begin
                  wc = 1'b1;
                  wdc = 1'b1;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_MOV: begin
                  res = b;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_COM: begin
                  res = ~b;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_INC: begin
                  res = b_inc;
                  wz = 1'b1;
               end
               instr_decode_pkg::OP_DECSZ: begin
                  res = b_dec;
                  skip = (b_dec == 8'h00);
               end
               instr_decode_pkg::OP_INCSZ: begin
                  res = b_inc;
                  skip = (b_inc == 8'h00);
               end
               instr_decode_pkg::OP_RRC: begin
                  res = {carry_o, b[7:1]};
                  c_val = b[0];
                  wc = 1'b1;
               end
               instr_decode_pkg::OP_RLC: begin
                  res = {b[6:0], carry_o};
                  c_val = b[7];
                  wc = 1'b1;
               end
               instr_decode_pkg::OP_SWAP: res = {b[3:0], b[7:4]};
               default: ;
            endcase
         end
         instr_decode_pkg::GRP_BIT: begin
            res = b;
            case (bcode)
               instr_decode_pkg::BIT_CLR: begin
                  res = b & ~bmask;
                  to_file = 1'b1;
               end
               instr_decode_pkg::BIT_SET: begin
                  res = b | bmask;
                  to_file = 1'b1;
               end
               instr_decode_pkg::BIT_TSC: skip = ~b[bsel];
               instr_decode_pkg::BIT_TSS: skip = b[bsel];
               default: ;
            endcase
         end
         instr_decode_pkg::GRP_CTL: begin
            jump = 1'b1;
            push = ~ir_reg[11];
         end
         default: begin
            to_acc = 1'b1;
            // Wildcards stand for don't-care bits
            casez (opc)
               4'b00??: res = lit;
               4'b01??: begin
                  res = lit;
                  pop = 1'b1;
               end
               instr_decode_pkg::LIT_IOR: begin
                  res = lit | acc_o;
                  wz = 1'b1;
               end
               instr_decode_pkg::LIT_AND: begin
                  res = lit & acc_o;
                  wz = 1'b1;
               end
               instr_decode_pkg::LIT_XOR: begin
                  res = lit ^ acc_o;
                  wz = 1'b1;
               end
               4'b11??: begin
                  wc = 1'b1;
                  wdc = 1'b1;
                  wz = 1'b1;
               end
               default: to_acc = 1'b0;
            endcase
         end
      endcase
   end

   wire redirect = jump | pop;
   wire [PC_W-1:0] pc_inc = pc_o + PC_W'(1);
   wire [SP_W-1:0] sp_top = sp_reg - SP_W'(1);
   wire tmr_write = to_file & (faddr == instr_decode_pkg::TIMER_ADDR);
   wire wdt_hit = sleep_hit | kick_hit;

   ////////////////////////////////////////////////////////////////////////
   // Phase sequencer: four clocks per instruction cycle

   always_comb begin
      case (ph_reg)
         instr_decode_pkg::PH_FETCH:
            ph_next = go ? instr_decode_pkg::PH_DECODE : instr_decode_pkg::PH_FETCH;
         instr_decode_pkg::PH_DECODE: ph_next = instr_decode_pkg::PH_READ;
         instr_decode_pkg::PH_READ: ph_next = instr_decode_pkg::PH_EXEC;
         instr_decode_pkg::PH_EXEC: ph_next = instr_decode_pkg::PH_FETCH;
         default: ph_next = instr_decode_pkg::PH_FETCH;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ph_reg <= instr_decode_pkg::PH_FETCH;
      end else begin
         ph_reg <= ph_next;
      end
   end

   // A flushed slot executes as a no-op
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ir_reg <= instr_decode_pkg::W_NOP;
      end else if (at_fetch && go) begin
         ir_reg <= discard_reg ? instr_decode_pkg::W_NOP : instr_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         discard_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else if (at_exec) begin
         discard_reg <= skip | redirect;
         hold_reg <= redirect;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program counter and return stack

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pc_o <= '0;
         sp_reg <= '0;
      end else if (at_exec) begin
         if (jump) begin
            pc_o <= target;
         end else if (pop) begin
            pc_o <= stack_mem[sp_top];
         end else if (!(discard_reg && hold_reg)) begin
            pc_o <= pc_inc;
         end
         if (push) begin
            sp_reg <= sp_reg + SP_W'(1);
         end else if (pop) begin
            sp_reg <= sp_top;
         end
      end
   end

   // Circular stack: overflow silently wraps over the oldest entry
   always_ff @(posedge clk_i) begin
      if (at_exec && push) begin
         stack_mem[sp_reg] <= pc_inc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // File register port: read after decode, write after execute

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         file_addr_o <= '0;
         file_rd_o <= 1'b0;
         port_change_clear_o <= 1'b0;
      end else begin
         if (at_decode) begin
            file_addr_o <= faddr;
         end
         file_rd_o <= at_decode & file_op;
         port_change_clear_o <= at_decode & file_op & (faddr == instr_decode_pkg::PORT_ADDR);
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         file_wr_o <= 1'b0;
         file_wdata_o <= '0;
      end else begin
         file_wr_o <= at_exec & to_file;
         if (at_exec) begin
            file_wdata_o <= res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Accumulator and status flags

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_o <= '0;
         carry_o <= 1'b0;
         digit_carry_o <= 1'b0;
         zero_o <= 1'b0;
      end else if (at_exec) begin
         if (to_acc) begin
            acc_o <= res;
         end
         if (wc) begin
            carry_o <= c_val;
         end
         if (wdc) begin
            digit_carry_o <= nib5[4];
         end
         if (wz) begin
            zero_o <= (res == 8'h00);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Standby, watchdog and prescaler side effects

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timeout_flag_o <= 1'b1;
         sleep_entered_flag_o <= 1'b1;
         standby_o <= 1'b0;
      end else begin
         if (at_exec && wdt_hit) begin
            timeout_flag_o <= 1'b1;
            sleep_entered_flag_o <= kick_hit;
         end
         // Entry wins over a wake in the same cycle
         if (at_exec && sleep_hit) begin
            standby_o <= 1'b1;
         end else if (wake_i) begin
            standby_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wdt_clear_o <= 1'b0;
         prescaler_clear_o <= 1'b0;
      end else begin
         wdt_clear_o <= at_exec & wdt_hit;
         prescaler_clear_o <= at_exec & ((tmr_write & psa_tmr) | (wdt_hit & ~psa_tmr));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port

   wire [15:0] stat_word = {10'h000, standby_o, timeout_flag_o, sleep_entered_flag_o,
                            zero_o, digit_carry_o, carry_o};
   wire [15:0] rd_mux = (reg_addr_i == instr_decode_pkg::REG_CTRL) ? {14'h0000, ctrl_reg} :
                        (reg_addr_i == instr_decode_pkg::REG_STAT) ? stat_word :
                        (reg_addr_i == instr_decode_pkg::REG_ACC) ? {8'h00, acc_o} :
                        16'(pc_o);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= instr_decode_pkg::CTRL_RESET;
         reg_rdata_o <= '0;
      end else begin
         if (reg_wr_i && reg_addr_i == instr_decode_pkg::REG_CTRL) begin
            ctrl_reg <= reg_wdata_i[1:0];
         end
         reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
      end
   end

endmodule

// [src/instr_decode_pkg.sv]
/*
 Constants, encodings and phase type for the 14-bit instruction decoder.
 Assumes a single clock domain; every user writes instr_decode_pkg::name.
*/
package instr_decode_pkg;

   // Word and field widths
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 11;
   localparam int STACK_D = 8;
   localparam int REG_DATA_W = 16;
   localparam int REG_ADDR_W = 2;

   // Oscillator periods in one instruction cycle
   localparam int OSC_PER_CYCLE = 4;

   // Format groups in the top two bits
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_CTL = 2'h2;
   localparam logic [1:0] GRP_LIT = 2'h3;

   // Byte-oriented operation codes
   localparam logic [3:0] OP_MISC = 4'h0;
   localparam logic [3:0] OP_CLR = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_IOR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_XOR = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOV = 4'h8;
   localparam logic [3:0] OP_COM = 4'h9;
   localparam logic [3:0] OP_INC = 4'hA;
   localparam logic [3:0] OP_DECSZ = 4'hB;
   localparam logic [3:0] OP_RRC = 4'hC;
   localparam logic [3:0] OP_RLC = 4'hD;
   localparam logic [3:0] OP_SWAP = 4'hE;
   localparam logic [3:0] OP_INCSZ = 4'hF;

   // Bit-oriented codes
   localparam logic [1:0] BIT_CLR = 2'h0;
   localparam logic [1:0] BIT_SET = 2'h1;
   localparam logic [1:0] BIT_TSC = 2'h2;
   localparam logic [1:0] BIT_TSS = 2'h3;

   // Literal codes that are fully decoded
   localparam logic [3:0] LIT_IOR = 4'h8;
   localparam logic [3:0] LIT_AND = 4'h9;
   localparam logic [3:0] LIT_XOR = 4'hA;

   // Fixed control words
   localparam logic [13:0] W_NOP = 14'h0000;
   localparam logic [13:0] W_RETURN = 14'h0008;
   localparam logic [13:0] W_RETINT = 14'h0009;
   localparam logic [13:0] W_SLEEP = 14'h0063;
   localparam logic [13:0] W_KICK = 14'h0064;

   // File addresses with side effects
   localparam logic [6:0] PORT_ADDR = 7'h05;
   localparam logic [6:0] TIMER_ADDR = 7'h01;

   // Register port map (word indices)
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_STAT = 2'h1;
   localparam logic [1:0] REG_ACC = 2'h2;
   localparam logic [1:0] REG_PC = 2'h3;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_PSA_TMR_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   typedef enum logic [3:0] {
      PH_FETCH = 4'h1,
      PH_DECODE = 4'h2,
      PH_READ = 4'h4,
      PH_EXEC = 4'h8
   } phase_type;

endpackage

// [tb/instr_decode_assertions.sv]
/*
 Concurrent checks on the decoder's file, program and side-effect ports.
 Assumes one clock domain; bound into every decoder instance.
*/
`timescale 1ns/10ps
module instr_decode_checker #(
   parameter int PC_W = 11
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [PC_W-1:0] pc_o,
   input wire logic [instr_decode_pkg::FADDR_W-1:0] file_addr_o,
   input wire logic file_rd_o,
   input wire logic file_wr_o,
   input wire logic prescaler_clear_o,
   input wire logic wdt_clear_o,
   input wire logic port_change_clear_o,
   input wire logic standby_o,
   input wire logic timeout_flag_o,
   input wire logic sleep_entered_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////////
   a_read_write: assert property (file_wr_o |-> $past(file_rd_o, 2))
      else $error("file write without its read");
   a_read_gap: assert property (file_rd_o |=> !file_rd_o [*3])
      else $error("file reads closer than four clocks");
   a_pc_hold: assert property ($changed(pc_o) |=> $stable(pc_o) [*3])
      else $error("program counter moved within a cycle");
   a_port_clear: assert property (port_change_clear_o ==
      (file_rd_o && file_addr_o == instr_decode_pkg::PORT_ADDR))
      else $error("port change clear not tied to port read");
   a_strobe_excl: assert property (!(file_rd_o && file_wr_o))
      else $error("file read and write together");
   a_write_addr: assert property (file_wr_o |-> $stable(file_addr_o))
      else $error("file address moved before write");
   a_presc_cause: assert property (prescaler_clear_o |-> wdt_clear_o ||
      file_addr_o == instr_decode_pkg::TIMER_ADDR)
      else $error("prescaler cleared without cause");
   a_kick_flag: assert property (wdt_clear_o |-> ##[0:1] timeout_flag_o)
      else $error("timeout flag not set by kick");
   a_standby_flags: assert property ($rose(standby_o) |-> ##[0:1]
      (timeout_flag_o && !sleep_entered_flag_o))
      else $error("standby flags wrong");
   a_standby_kick: assert property ($rose(standby_o) |->
      (wdt_clear_o || $past(wdt_clear_o)))
      else $error("standby without watchdog clear");
   c_write: cover property (file_wr_o);
   c_standby: cover property ($rose(standby_o));
   c_port: cover property (port_change_clear_o);
endmodule

bind instr_decode_14bit instr_decode_checker #(.PC_W(PC_W)) u_checker (.clk_i, .reset_n_i,
   .pc_o, .file_addr_o, .file_rd_o, .file_wr_o, .prescaler_clear_o, .wdt_clear_o,
   .port_change_clear_o, .standby_o, .timeout_flag_o, .sleep_entered_flag_o);

// [tb/prog_file_model.sv]
/*
 Behavioural program memory and file register space facing the decoder.
 Assumes one clock; the bench preloads prog, and regs in three of its five scenarios, before each reset.
*/
`timescale 1ns/10ps
module prog_file_model (
   // Program side
   input wire logic clk_i,
   input wire logic [10:0] pc_i,
   output logic [13:0] instr_o,
   // File side
   input wire logic [6:0] addr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i
);
   logic [13:0] prog [0:2047];
   logic [7:0] regs [0:127];
   assign instr_o = prog[pc_i];
   initial rdata_o = 8'h00;
   // Stale data inverted each idle clock so a sample one clock late never passes
   always @(posedge clk_i) begin
      rdata_o <= rd_i ? regs[addr_i] : ~rdata_o;
      if (wr_i) regs[addr_i] <= wdata_i;
   end
endmodule

// [tb/testbench.sv]
/*
 Self-checking bench: each scenario loads a program, resets and judges results.
 Assumes the partner model answers program and file accesses.
*/
`timescale 1ns/10ps
module testbench;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [10:0] pc_o;
   logic [13:0] instr_i;
   logic [6:0] file_addr_o;
   logic file_rd_o, file_wr_o, prescaler_clear_o, wdt_clear_o, standby_o;
   logic [7:0] file_rdata_i, file_wdata_o;
   logic [7:0] pin_level_i = 8'h00;
   logic wake_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [1:0] reg_addr_i = 2'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [15:0] reg_rdata_o, d;
   int bad_count = 0;
   int comparisons = 0;
   int wdt_count, psc_count;
   always #2.5 clk_i = ~clk_i;
   instr_decode_14bit DUT (.clk_i, .reset_n_i, .pc_o, .instr_i, .file_addr_o, .file_rd_o,
      .file_rdata_i, .file_wr_o, .file_wdata_o, .pin_level_i, .prescaler_clear_o,
      .wdt_clear_o, .port_change_clear_o(), .standby_o, .wake_i, .acc_o(), .carry_o(),
      .digit_carry_o(), .zero_o(), .timeout_flag_o(), .sleep_entered_flag_o(),
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
   prog_file_model m (.clk_i, .pc_i(pc_o), .instr_o(instr_i), .addr_i(file_addr_o),
      .rd_i(file_rd_o), .rdata_o(file_rdata_i), .wr_i(file_wr_o), .wdata_i(file_wdata_o));
   always @(posedge clk_i) begin
      if (wdt_clear_o === 1'b1) wdt_count++;
      if (prescaler_clear_o === 1'b1) psc_count++;
   end
   ////////////////////////////////////////////////////////////////
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task boot;
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      wdt_count = 0;
      psc_count = 0;
   endtask
   task reg_write(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task reg_read(input logic [1:0] a);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   // Edges counted from reset release; pc moves only at execute edges
   task wait_pc(input logic [10:0] t, input int exp);
      int n;
      n = 0;
      while (n < 300 && pc_o !== t) begin
         @(posedge clk_i);
         n++;
         #1;
      end
      check(16'(n), 16'(exp));
   endtask
   ////////////////////////////////////////////////////////////////
   task byte_ops;
      m.regs[7'h20] = 8'hC1;
      m.regs[7'h21] = 8'hF0;
      m.regs[7'h22] = 8'h05;
      m.prog[0] = 14'h303F;
      m.prog[1] = 14'h07A0;
      m.prog[2] = 14'h0521;
      m.prog[3] = 14'h04A2;
      m.prog[4] = 14'h2804;
      boot;
      wait_pc(11'h004, 16);
      reg_read(instr_decode_pkg::REG_ACC);
      check(d, 16'h0030);
      reg_read(instr_decode_pkg::REG_STAT);
      check(d, 16'h001B);
      reg_read(instr_decode_pkg::REG_CTRL);
      check(d, 16'h0001);
      check({8'h00, m.regs[7'h20]}, 16'h0000);
      check({8'h00, m.regs[7'h22]}, 16'h0035);
   endtask
   task skip_ops;
      m.regs[7'h30] = 8'h01;
      m.regs[7'h31] = 8'h10;
      m.regs[7'h32] = 8'hFF;
      m.prog[0] = 14'h0BB0;
      m.prog[1] = 14'h30AA;
      m.prog[2] = 14'h0FB1;
      m.prog[3] = 14'h3A11;
      m.prog[4] = 14'h0F32;
      m.prog[5] = 14'h3099;
      m.prog[6] = 14'h2806;
      boot;
      wait_pc(11'h006, 24);
      reg_read(instr_decode_pkg::REG_ACC);
      check(d, 16'h0000);
      reg_read(instr_decode_pkg::REG_STAT);
      check(d, 16'h0018);
      check({8'h00, m.regs[7'h30]}, 16'h0000);
      check({8'h00, m.regs[7'h31]}, 16'h0011);
   endtask
   task bit_ops;
      m.regs[7'h40] = 8'h00;
      m.regs[7'h41] = 8'hFF;
      m.regs[7'h05] = 8'hFF;
      m.prog[0] = 14'h17C0;
      m.prog[1] = 14'h1041;
      m.prog[2] = 14'h1BC0;
      m.prog[3] = 14'h3001;
      m.prog[4] = 14'h1CC1;
      m.prog[5] = 14'h3077;
      m.prog[6] = 14'h0D85;
      m.prog[7] = 14'h2807;
      pin_level_i <= 8'h81;
      boot;
      wait_pc(11'h007, 28);
      reg_read(instr_decode_pkg::REG_ACC);
      check(d, 16'h0001);
      reg_read(instr_decode_pkg::REG_STAT);
      check(d, 16'h0019);
      check({8'h00, m.regs[7'h40]}, 16'h0080);
      check({8'h00, m.regs[7'h41]}, 16'h00FE);
      check({8'h00, m.regs[7'h05]}, 16'h0002);
   endtask
   task control_ops;
      m.prog[0] = 14'h2010;
      m.prog[1] = 14'h2801;
      m.prog[16] = 14'h380F;
      m.prog[17] = 14'h393C;
      m.prog[18] = 14'h3F04;
      m.prog[19] = 14'h3D10;
      m.prog[20] = 14'h375A;
      boot;
      wait_pc(11'h001, 28);
      reg_read(instr_decode_pkg::REG_ACC);
      check(d, 16'h005A);
      reg_read(instr_decode_pkg::REG_STAT);
      check(d, 16'h001F);
   endtask
   task standby_ops;
      m.prog[0] = 14'h0181;
      m.prog[1] = 14'h0064;
      m.prog[2] = 14'h3BFF;
      m.prog[3] = 14'h0063;
      m.prog[4] = 14'h2804;
      boot;
      reg_write(instr_decode_pkg::REG_CTRL, 8'h03);
      repeat (30) @(posedge clk_i);
      reg_read(instr_decode_pkg::REG_STAT);
      check(d & 16'h0038, 16'h0030);
      check(16'(wdt_count), 16'h0002);
      check(16'(psc_count), 16'h0001);
      reg_write(instr_decode_pkg::REG_ACC, 8'hEE);
      reg_read(instr_decode_pkg::REG_ACC);
      check(d, 16'h0000);
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      reg_read(instr_decode_pkg::REG_STAT);
      check(d & 16'h0020, 16'h0000);
      reg_read(instr_decode_pkg::REG_PC);
      check(d, 16'h0004);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #10000;
      bad_count++;
      finish_test;
   end
   initial begin
      byte_ops;
      skip_ops;
      bit_ops;
      control_ops;
      standby_ops;
      finish_test;
   end
endmodule
